// [dv/rcp_mic_model.sv]
// Purpose: two pdm microphones on each of the four data lines
// Assumes: mics are set up for the edges software programmed
// Notes:   line is always driven by one of the pair, never left floating
`timescale 1ns/1ps
`default_nettype none
module rcp_mic_model (
	// pdm clock from the device
	input  wire logic       pdm_clock_out,
	// per line: edge choice, odd and even channel bits
	input  wire logic [3:0] edge_sel,
	input  wire logic [3:0] odd_bits,
	input  wire logic [3:0] even_bits,
	// data lines
	output logic [3:0]      pdm_data_in
);
	// each mic drives the half period ending in its own latching edge
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pdm_data_in[i] = (pdm_clock_out ^ edge_sel[i]) ? odd_bits[i] : even_bits[i];
		end
	end
endmodule : rcp_mic_model
`default_nettype wire

// [dv/rcp_monitor.sv]
// Purpose: port checks on rcp_top
// Assumes: one clock domain, async active-low reset
// Notes:   bound into rcp_top below
`timescale 1ns/1ps
`default_nettype none
module rcp_monitor
	import rcp_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// bus
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest,
	// link and state
	input  wire logic        pdm_clock_out,
	input  wire logic [7:0]  pdm_ch_valid,
	input  wire rcp_clk_s    clk_state,
	input  wire logic        drive_bclk_frame_sync
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence req_taken;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence ack_once;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	answer_next_a: assert property (req_taken |=> ack_once) else $error("late bus answer");
	idle_wait_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
		else $error("answer without request");
	root_rsvd_a: assert property (
		!avs_waitrequest && avs_read && avs_address == ROOT_CLOCK_IDX |-> avs_readdata[2:0] == 3'h0)
		else $error("root reserved bits set");
	edge_rsvd_a: assert property (
		!avs_waitrequest && avs_read && avs_address == PDM_EDGE_IDX |-> avs_readdata[3:0] == 4'h0)
		else $error("edge reserved bits set");
	ratio_legal_a: assert property (clk_state.ratio_applied |-> clk_state.ratio inside
		{12'h040, 12'h100, 12'h180, 12'h200, 12'h300, 12'h400, 12'h600, 12'h900})
		else $error("illegal ratio");
	mclk_ratio_a: assert property (
		clk_state.root == RCP_ROOT_MASTER_CLK |-> clk_state.ratio_applied)
		else $error("ratio unused with master clock root");
	slave_ratio_a: assert property (
		!drive_bclk_frame_sync && clk_state.root != RCP_ROOT_MASTER_CLK |-> !clk_state.ratio_applied)
		else $error("ratio used in slave without master clock root");
	master_pll_a: assert property (
		drive_bclk_frame_sync |-> clk_state.root == RCP_ROOT_PLL && clk_state.ratio_applied)
		else $error("master mode state wrong");
	pdm_half_a: assert property ($rose(pdm_clock_out) |-> pdm_clock_out[*8])
		else $error("pdm clock high too short");
	pair_split_a: assert property (
		(pdm_ch_valid & (pdm_ch_valid << 1) & 8'hAA) == 8'h00)
		else $error("both channels of one line latched together");
endmodule : rcp_monitor
bind rcp_top rcp_monitor i_rcp_monitor (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write,
	.avs_readdata, .avs_waitrequest, .pdm_clock_out, .pdm_ch_valid, .clk_state, .drive_bclk_frame_sync);
`default_nettype wire

// [dv/tb_top.sv]
// Purpose: register, clock state and pdm link tests for rcp_top
// Assumes: one wait state per access; half periods 16/32/65/8 cycles
// Notes:   mic model follows the programmed edges
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import rcp_pkg::*;
;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [3:0]  pdm_data_in;
	logic        pdm_clock_out;
	logic [7:0]  pdm_ch_bits;
	rcp_clk_s    clk_state;
	logic        drive_bclk_frame_sync;
	logic [3:0]  edge_sel = 4'h0;
	logic [3:0]  odd_bits = 4'h0;
	logic [31:0] q;
	logic [7:0]  cfg;
	logic [7:0]  exp_bits;
	int          errors = 0;
	int          compares = 0;
	realtime     t0;
	localparam logic [11:0] RATIO_TBL [8] = '{12'h040, 12'h100, 12'h180, 12'h200, 12'h300,
		12'h400, 12'h600, 12'h900};
	localparam int PERIOD_TBL [4] = '{32, 64, 130, 16};
	rcp_top i_rcp_top (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .pdm_data_in, .pdm_clock_out,
		.pdm_ch_bits, .pdm_ch_valid(), .clk_state, .drive_bclk_frame_sync);
	rcp_mic_model i_rcp_mic_model (.pdm_clock_out, .edge_sel, .odd_bits,
		.even_bits(~odd_bits), .pdm_data_in);
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %0h seen %0h", name, exp, seen);
		end
	endtask : check
	task automatic end_of_test;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_of_test
	// waitrequest is read at the edge itself, so the pre-edge value decides
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= wr;
		avs_read <= !wr;
		// only the watchdog ends a wait that never sees an answer
		do begin
			@(posedge sys_clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
		repeat (2) @(posedge sys_clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		check("readdata", q, {24'h0, exp});
	endtask : rd
	initial begin
		#300000;
		errors++;
		end_of_test();
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		rd(PDM_CLK_IDX, 8'h40);
		rd(PDM_EDGE_IDX, 8'h00);
		rd(ROOT_CLOCK_IDX, 8'h10);
		wr(8'h05, 8'hFF);
		rd(8'h05, 8'h00);
		wr(ROOT_CLOCK_IDX, 8'hFF);
		rd(ROOT_CLOCK_IDX, 8'hF8);
		wr(PDM_EDGE_IDX, 8'hFF);
		rd(PDM_EDGE_IDX, 8'hF0);
		wr(PDM_CLK_IDX, 8'hFF);
		rd(PDM_CLK_IDX, 8'hFF);
		avs_byteenable <= 4'h0;
		wr(PDM_CLK_IDX, 8'h40);
		avs_byteenable <= 4'hF;
		rd(PDM_CLK_IDX, 8'hFF);
		wr(MASTER_CFG_IDX, 8'h20);
		for (int c = 0; c < 8; c++) begin
			wr(ROOT_CLOCK_IDX, 8'h80 | 8'(c << 3));
			check("ratio", clk_state.ratio, RATIO_TBL[c]);
			check("root", clk_state.root, RCP_ROOT_MASTER_CLK);
			check("applied", clk_state.ratio_applied, 1'b1);
		end
		check("from_ratio", clk_state.freq_from_ratio, 1'b0);
		wr(ROOT_CLOCK_IDX, 8'h40);
		check("root", clk_state.root, RCP_ROOT_BIT_CLK);
		check("applied", clk_state.ratio_applied, 1'b0);
		check("from_ratio", clk_state.freq_from_ratio, 1'b1);
		wr(MASTER_CFG_IDX, 8'h8F);
		check("root", clk_state.root, RCP_ROOT_PLL);
		check("master", drive_bclk_frame_sync, 1'b1);
		check("family", clk_state.family_441, 1'b1);
		check("freq", clk_state.freq_code, 3'h7);
		wr(MASTER_CFG_IDX, 8'h00);
		wr(ROOT_CLOCK_IDX, 8'h80);
		check("root", clk_state.root, RCP_ROOT_PLL);
		check("applied", clk_state.ratio_applied, 1'b0);
		for (int k = 0; k < 4; k++) begin
			wr(PDM_CLK_IDX, 8'h40 | 8'(k));
			repeat (2) @(posedge pdm_clock_out);
			t0 = $realtime;
			@(posedge pdm_clock_out);
			check("period", int'(($realtime - t0) / 10.0), PERIOD_TBL[k]);
		end
		wr(PDM_CLK_IDX, 8'h40);
		for (int j = 0; j < 4; j++) begin
			cfg = {4'(j * 5), 4'h0};
			wr(PDM_EDGE_IDX, cfg);
			edge_sel <= {cfg[4], cfg[5], cfg[6], cfg[7]};
			odd_bits <= j[0] ? 4'h3 : 4'h5;
			repeat (6) @(posedge pdm_clock_out);
			@(posedge sys_clk);
			for (int i = 0; i < 4; i++) begin
				exp_bits[2 * i] = odd_bits[i];
				exp_bits[2 * i + 1] = !odd_bits[i];
			end
			check("ch_bits", pdm_ch_bits, exp_bits);
		end
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire

// [logic/rcp_pdm_capture.sv]
// Purpose: synchronises four pdm data pins and latches two channels per pin
// Assumes: pins are asynchronous; three flop synchroniser, change accepted on agreement
// Notes:   sampling at the edge pulse sees data from just before the edge
`timescale 1ns/1ps
`default_nettype none
module rcp_pdm_capture
	import rcp_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// edges and config
	input  wire logic       rise_pulse,
	input  wire logic       fall_pulse,
	input  wire logic [3:0] edges,
	// pins
	input  wire logic [3:0] pdm_data_in,
	// channel bits
	output logic [7:0]      ch_bits,
	output logic [7:0]      ch_valid
);
	logic [3:0] s1, s2, s3, clean, next_clean;
	logic [7:0] next_bits, next_valid;

	always_comb begin
		next_clean = clean;
		for (int i = 0; i < 4; i++) begin
			if (s2[i] == s3[i]) begin
				next_clean[i] = s3[i];
			end
		end
		next_bits  = ch_bits;
		next_valid = 8'h00;
		for (int i = 0; i < 4; i++) begin
			// odd channel on falling edge unless the input's edge bit swaps it
			if (edges[3-i] ? rise_pulse : fall_pulse) begin // R7 R8 R9 R10
				next_bits[2*i]  = clean[i];
				next_valid[2*i] = 1'b1;
			end
			if (edges[3-i] ? fall_pulse : rise_pulse) begin // R7 R8 R9 R10 R12
				next_bits[2*i+1]  = clean[i];
				next_valid[2*i+1] = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1       <= 4'h0;
			s2       <= 4'h0;
			s3       <= 4'h0;
			clean    <= 4'h0;
			ch_bits  <= 8'h00;
			ch_valid <= 8'h00;
		end else begin
			s1       <= pdm_data_in;
			s2       <= s1;
			s3       <= s2;
			clean    <= next_clean;
			ch_bits  <= next_bits;
			ch_valid <= next_valid;
		end
	end
endmodule : rcp_pdm_capture
`default_nettype wire

// [logic/rcp_pdm_clk_gen.sv]
// Purpose: divides sys_clk into the pdm clock and flags its edges
// Assumes: divider code may change at any time; new rate takes effect at next half period
// Notes:   rise/fall pulses are one cycle wide, aligned with the clock transition
`timescale 1ns/1ps
`default_nettype none
module rcp_pdm_clk_gen
	import rcp_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// control
	input  wire logic [1:0] div_code,
	// pdm clock
	output logic            pdm_clk,
	output logic            rise_pulse,
	output logic            fall_pulse
);
	logic [HALF_W-1:0] cnt, next_cnt, half, cur_half, next_cur_half;
	logic              next_pdm_clk, next_rise, next_fall;

	always_comb begin
		case (div_code) // R5
			2'h0: half = HALF_W'(PDM_HALF_CODE0);
			2'h1: half = HALF_W'(PDM_HALF_CODE1);
			2'h2: half = HALF_W'(PDM_HALF_CODE2);
			default: half = HALF_W'(PDM_HALF_CODE3);
		endcase
		next_cnt      = cnt + 8'h01;
		next_cur_half = cur_half;
		next_pdm_clk  = pdm_clk;
		next_rise     = 1'b0;
		next_fall     = 1'b0;
		// new rate is loaded only at a transition, so no half period is cut short
		if (cnt >= cur_half - 8'h01) begin
			next_cnt      = 8'h00;
			next_cur_half = half;
			next_pdm_clk = ~pdm_clk;
			next_rise    = ~pdm_clk;
			next_fall    = pdm_clk;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt        <= 8'h00;
			cur_half   <= HALF_W'(PDM_HALF_CODE0);
			pdm_clk    <= 1'b0;
			rise_pulse <= 1'b0;
			fall_pulse <= 1'b0;
		end else begin
			cnt        <= next_cnt;
			cur_half   <= next_cur_half;
			pdm_clk    <= next_pdm_clk;
			rise_pulse <= next_rise;
			fall_pulse <= next_fall;
		end
	end
endmodule : rcp_pdm_clk_gen
`default_nettype wire

// [logic/rcp_pkg.sv]
// Purpose: shared constants and types for the root clock and pdm input block
// Assumes: 32-bit avalon-mm slave, word addressed by register index
// Notes:   offsets are register indices; byte address is four times the index
package rcp_pkg;
	localparam logic [7:0] ROOT_CLOCK_IDX  = 8'h16;
	localparam logic [7:0] PDM_CLK_IDX     = 8'h1F;
	localparam logic [7:0] PDM_EDGE_IDX    = 8'h20;
	localparam logic [7:0] MASTER_CFG_IDX  = 8'h13;
	localparam logic [7:0] STATUS_IDX      = 8'h30;
	localparam logic [7:0] ROOT_CLOCK_RST  = 8'h10;
	localparam logic [7:0] PDM_CLK_RST     = 8'h40;
	localparam logic [7:0] PDM_EDGE_RST    = 8'h00;
	localparam logic [7:0] MASTER_CFG_RST  = 8'h02;
	localparam logic [7:0] ROOT_CLOCK_WMASK = 8'hF8;
	localparam logic [7:0] PDM_EDGE_WMASK  = 8'hF0;
	// field positions
	localparam int ROOT_SRC_BIT   = 7;
	localparam int FREQ_MODE_BIT  = 6;
	localparam int RATIO_LSB      = 3;
	localparam int EDGE_A_BIT     = 7;
	localparam int MS_BIT         = 7;
	localparam int PLL_OFF_BIT    = 5;
	localparam int FAMILY_BIT     = 3;
	// pdm clock half periods in sys_clk cycles at 100 MHz (approximation)
	localparam int SYS_CLK_KHZ    = 100000;
	localparam int PDM_KHZ_CODE0  = 3072;
	localparam int PDM_HALF_CODE0 = SYS_CLK_KHZ / (2 * PDM_KHZ_CODE0);
	localparam int PDM_HALF_CODE1 = SYS_CLK_KHZ / (2 * (PDM_KHZ_CODE0 / 2));
	localparam int PDM_HALF_CODE2 = SYS_CLK_KHZ / (2 * (PDM_KHZ_CODE0 / 4));
	localparam int PDM_HALF_CODE3 = SYS_CLK_KHZ / (2 * (PDM_KHZ_CODE0 * 2));
	localparam int HALF_W         = 8;

	typedef enum logic [1:0] {RCP_ROOT_BIT_CLK, RCP_ROOT_MASTER_CLK, RCP_ROOT_PLL} rcp_root_e;

	typedef struct packed {
		logic       master_slave_select;
		logic       auto_config_pll_off;
		logic       sample_rate_family;
		logic [2:0] master_clock_freq_code;
		logic       pll_off_root_source_select;
		logic       master_clock_freq_mode;
		logic [2:0] ratio_code;
		logic [1:0] pdm_clock_divider_code;
		logic [3:0] edges;
	} rcp_cfg_s;

	typedef struct packed {
		rcp_root_e   root;
		logic        ratio_applied;
		logic [11:0] ratio;
		logic        freq_from_ratio;
		logic [2:0]  freq_code;
		logic        family_441;
	} rcp_clk_s;
endpackage : rcp_pkg

// [logic/rcp_top.sv]
// Purpose: root clock selection, ratio decode, pdm clock and pdm input edge control
// Assumes: avalon-mm slave with waitrequest, one wait state on every access
// Notes:   clock choice is reported as decoded state; no real clock muxing here
// Overview of operation
// (R1) slave, pll off: root is bit clock if source bit 0, master clock if 1
// (R2) mode bit 0: freq from absolute code; 1: freq from ratio field
// (R3) ratio field bits 5:3 decodes 64,256,384,512,768,1024,1536,2304
// (R4) ratio applies in master mode or slave with master clock root
// (R5) two-bit divider code picks pdm clock rate
// (R6) pdm clock register resets to 40h
// (R7) input a: ch1 falling, ch2 rising; swapped when edge bit set
// (R8) input b: ch3 falling, ch4 rising; swapped when edge bit set
// (R9) input c: ch5 falling, ch6 rising; swapped when edge bit set
// (R10) input d: ch7 falling, ch8 rising; swapped when edge bit set
// (R11) edge register resets to zero
// (R12) microphones on one input drive on opposite edges as programmed
// (R13) pll-off bit disables pll in auto mode, enabling root source choice
// (R14) family bit: 0 selects 48 kHz family, 1 selects 44.1 kHz
// (R15) one bit picks master (drive clocks) or slave (accept clocks)
// (R16) mode 0: freq code 0 is 12 MHz up to code 7 at 24.576 MHz
// (R17) read-only reserved bits read zero and ignore writes
// (R18) software keeps pdm clock reserved bits at reset value
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rcp_top
	import rcp_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// avalon-mm slave
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// pdm link
	input  wire logic [3:0]  pdm_data_in,
	output logic             pdm_clock_out,
	output logic [7:0]       pdm_ch_bits,
	output logic [7:0]       pdm_ch_valid,
	// clock state
	output rcp_clk_s         clk_state,
	output logic             drive_bclk_frame_sync
);
	logic [7:0]  root_clock_source_config, next_root;
	logic [7:0]  pdm_clock_divider_config, next_pdm_clock_out;
	logic [7:0]  pdm_input_edge_config, next_edge;
	logic [7:0]  master_cfg, next_master;
	logic        ack, next_ack;
	logic [31:0] next_rdata;
	rcp_cfg_s    cfg;
	rcp_clk_s    next_clk;
	logic        gen_clk, gen_rise, gen_fall;
	logic [7:0]  cap_bits, cap_valid;

	function automatic logic [11:0] ratio_of(input logic [2:0] code);
		case (code) // R3
			3'h0: ratio_of = 12'h040;
			3'h1: ratio_of = 12'h100;
			3'h2: ratio_of = 12'h180;
			3'h3: ratio_of = 12'h200;
			3'h4: ratio_of = 12'h300;
			3'h5: ratio_of = 12'h400;
			3'h6: ratio_of = 12'h600;
			default: ratio_of = 12'h900;
		endcase
	endfunction : ratio_of

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
		input logic [7:0] mask);
		merge = (old & ~mask) | (wd & mask);
	endfunction : merge

	assign cfg.master_slave_select        = master_cfg[MS_BIT];
	assign cfg.auto_config_pll_off        = master_cfg[PLL_OFF_BIT];
	assign cfg.sample_rate_family         = master_cfg[FAMILY_BIT];
	assign cfg.master_clock_freq_code     = master_cfg[2:0];
	assign cfg.pll_off_root_source_select = root_clock_source_config[ROOT_SRC_BIT];
	assign cfg.master_clock_freq_mode     = root_clock_source_config[FREQ_MODE_BIT];
	assign cfg.ratio_code = root_clock_source_config[RATIO_LSB+2:RATIO_LSB];
	assign cfg.pdm_clock_divider_code     = pdm_clock_divider_config[1:0];
	assign cfg.edges = pdm_input_edge_config[EDGE_A_BIT:EDGE_A_BIT-3];

	// register bus: every access waits one cycle, so waitrequest drops in cycle 1
	always_comb begin
		next_root   = root_clock_source_config;
		next_pdm_clock_out = pdm_clock_divider_config;
		next_edge   = pdm_input_edge_config;
		next_master = master_cfg;
		next_ack    = (avs_read | avs_write) & ~ack;
		next_rdata  = avs_readdata;
		// a write lands at the edge where waitrequest is seen low
		if (avs_write && ack && avs_byteenable[0]) begin
			case (avs_address)
				ROOT_CLOCK_IDX: next_root = merge(root_clock_source_config,
					avs_writedata[7:0], ROOT_CLOCK_WMASK); // R17
				PDM_CLK_IDX:    next_pdm_clock_out = avs_writedata[7:0]; // R18
				PDM_EDGE_IDX:   next_edge = merge(pdm_input_edge_config,
					avs_writedata[7:0], PDM_EDGE_WMASK); // R17
				MASTER_CFG_IDX: next_master = avs_writedata[7:0];
				default: ;
			endcase
		end
		if (avs_read && !ack) begin
			case (avs_address)
				ROOT_CLOCK_IDX: next_rdata = {24'h000000, root_clock_source_config};
				PDM_CLK_IDX:    next_rdata = {24'h000000, pdm_clock_divider_config};
				PDM_EDGE_IDX:   next_rdata = {24'h000000, pdm_input_edge_config};
				MASTER_CFG_IDX: next_rdata = {24'h000000, master_cfg};
				STATUS_IDX:     next_rdata = {12'h000, clk_state};
				default:        next_rdata = 32'h00000000;
			endcase
		end
	end

	// clock selection decode
	always_comb begin
		next_clk.family_441 = cfg.sample_rate_family; // R14
		next_clk.ratio      = ratio_of(cfg.ratio_code);
		next_clk.freq_code  = cfg.master_clock_freq_code; // R16
		next_clk.freq_from_ratio = cfg.master_clock_freq_mode; // R2
		if (cfg.master_slave_select || !cfg.auto_config_pll_off) begin // R13
			next_clk.root = RCP_ROOT_PLL;
		end else if (cfg.pll_off_root_source_select) begin // R1
			next_clk.root = RCP_ROOT_MASTER_CLK;
		end else begin
			next_clk.root = RCP_ROOT_BIT_CLK;
		end
		next_clk.ratio_applied = cfg.master_slave_select
			| (next_clk.root == RCP_ROOT_MASTER_CLK); // R4
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			root_clock_source_config <= ROOT_CLOCK_RST;
			pdm_clock_divider_config <= PDM_CLK_RST; // R6
			pdm_input_edge_config    <= PDM_EDGE_RST; // R11
			master_cfg               <= MASTER_CFG_RST;
			ack                      <= 1'b0;
			avs_waitrequest          <= 1'b1;
			avs_readdata             <= 32'h00000000;
			clk_state                <= '0;
			drive_bclk_frame_sync         <= 1'b0;
			pdm_clock_out            <= 1'b0;
			pdm_ch_bits              <= 8'h00;
			pdm_ch_valid             <= 8'h00;
		end else begin
			root_clock_source_config <= next_root;
			pdm_clock_divider_config <= next_pdm_clock_out;
			pdm_input_edge_config    <= next_edge;
			master_cfg               <= next_master;
			ack                      <= next_ack;
			avs_waitrequest          <= ~next_ack;
			avs_readdata             <= next_rdata;
			clk_state                <= next_clk;
			drive_bclk_frame_sync         <= cfg.master_slave_select; // R15
			pdm_clock_out            <= gen_clk;
			pdm_ch_bits              <= cap_bits;
			pdm_ch_valid             <= cap_valid;
		end
	end

	rcp_pdm_clk_gen u_clk (
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.div_code   (cfg.pdm_clock_divider_code),
		.pdm_clk    (gen_clk),
		.rise_pulse (gen_rise),
		.fall_pulse (gen_fall)
	);

	rcp_pdm_capture u_cap (
		.sys_clk     (sys_clk),
		.rst_n       (rst_n),
		.rise_pulse  (gen_rise),
		.fall_pulse  (gen_fall),
		.edges       (cfg.edges),
		.pdm_data_in (pdm_data_in),
		.ch_bits     (cap_bits),
		.ch_valid    (cap_valid)
	);
endmodule : rcp_top
`default_nettype wire
